/* shared/dcc_pkg.sv */
// constants, field layouts and carriers shared by the dual comparator control block
package dcc_pkg;

    // ------------------------------------------------------------------
    // bus and channel geometry
    // ------------------------------------------------------------------
    localparam int DCC_APB_AW = 16;
    localparam int DCC_APB_DW = 32;
    localparam int DCC_REG_W = 8;
    localparam int DCC_NCH = 2;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [11:0] DCC_IDX_STATUS = 12'hf70;
    localparam logic [11:0] DCC_IDX_CTRL_LO = 12'hfd1;
    localparam logic [11:0] DCC_IDX_CTRL_HI = 12'hfd2;
    localparam logic [11:0] DCC_IDX_FLAG = 12'hfd3;
    localparam logic [15:0] DCC_ADDR_STATUS = {2'h0, DCC_IDX_STATUS, 2'h0};
    localparam logic [15:0] DCC_ADDR_CTRL_LO = {2'h0, DCC_IDX_CTRL_LO, 2'h0};
    localparam logic [15:0] DCC_ADDR_CTRL_HI = {2'h0, DCC_IDX_CTRL_HI, 2'h0};
    localparam logic [15:0] DCC_ADDR_FLAG = {2'h0, DCC_IDX_FLAG, 2'h0};

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int DCC_STATUS_LSB = 0;
    localparam int DCC_FLAG_LSB = 5;
    localparam logic [7:0] DCC_CTRL_RESET = 8'h1f;
    localparam logic [7:0] DCC_FLAG_RESET = 8'h00;
    localparam logic DCC_RESULT_RESET = 1'b1;

    // ------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DCC_EV_OFF = 2'h0,
        DCC_EV_RISE = 2'h1,
        DCC_EV_FALL = 2'h2,
        DCC_EV_ANY = 2'h3
    } dcc_evpol_e;

    typedef enum logic [1:0] {
        DCC_NEG_PIN = 2'h0,
        DCC_NEG_ALT_A = 2'h1,
        DCC_NEG_ALT_B = 2'h2,
        DCC_NEG_FIXED = 2'h3
    } dcc_negsel_e;

    // inverting-side source actually switched in by the analog core
    typedef enum logic [1:0] {
        DCC_SRC_NEG_PIN = 2'h0,
        DCC_SRC_CHARGE_TIME = 2'h1,
        DCC_SRC_EXTRA_PIN = 2'h2,
        DCC_SRC_FIXED_REF = 2'h3
    } dcc_negsrc_e;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic comparator_on;
        logic output_pin_enable;
        logic output_invert;
        dcc_evpol_e event_polarity_select;
        logic positive_ref_select;
        dcc_negsel_e negative_channel_select;
    } dcc_ctrl_s;

    // steering sent to one analog comparator core
    typedef struct packed {
        logic enable;
        logic pos_from_ladder;
        dcc_negsrc_e neg_source;
    } dcc_analog_s;

endpackage

/* logic/dcc_sync.sv */
// two-stage level synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ns
module dcc_sync #(
    parameter int W = 2,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    // ------------------------------------------------------------------
    // next values; stage1 feeds stage2 only
    // ------------------------------------------------------------------
    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (ce) begin
            next_stage1 = async_in;
            next_stage2 = stage1;
        end
    end

    // registers, constant under reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {W{RESET_LEVEL}};
            stage2 <= {W{RESET_LEVEL}};
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out = stage2;
endmodule // dcc_sync

/* logic/dcc_channel.sv */
// one comparator channel: polarity, disable hold and edge-selectable event
`timescale 1ns/1ns
module dcc_channel (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire dcc_pkg::dcc_ctrl_s ctrl,
    input wire logic raw_sync,
    output logic result,
    output logic event_hit
);
    import dcc_pkg::*;

    logic prev_result;
    logic was_on;
    logic next_prev_result;
    logic next_was_on;
    logic rise;
    logic fall;

    // ------------------------------------------------------------------
    // polarity-adjusted result, held at reset level while off
    // ------------------------------------------------------------------
    // held while off
    always_comb begin
        result = DCC_RESULT_RESET;
        if (ctrl.comparator_on) begin
            // invert before status, pin and events
            result = raw_sync ^ ctrl.output_invert;
        end
    end

    // edges are seen on the adjusted result, so inverting swaps them
    // adjusted-result edges
    assign rise = result & ~prev_result;
    assign fall = ~result & prev_result;

    // event select; nothing from a channel that is or just was off
    always_comb begin
        event_hit = 1'b0;
        if (ce && ctrl.comparator_on && was_on) begin
            unique case (ctrl.event_polarity_select)
                DCC_EV_OFF: event_hit = 1'b0;
                DCC_EV_RISE: event_hit = rise;
                DCC_EV_FALL: event_hit = fall;
                DCC_EV_ANY: event_hit = rise | fall;
            endcase
        end
    end

    // history next values
    always_comb begin
        next_prev_result = prev_result;
        next_was_on = was_on;
        if (ce) begin
            next_prev_result = result;
            next_was_on = ctrl.comparator_on;
        end
    end

    // history registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_result <= DCC_RESULT_RESET;
            was_on <= 1'b0;
        end else begin
            prev_result <= next_prev_result;
            was_on <= next_was_on;
        end
    end
endmodule // dcc_channel

/* logic/dcc_top.sv */
// dual comparator control: APB registers, input steering, pins and event flags
`timescale 1ns/1ns
module dcc_top #(
    parameter dcc_pkg::dcc_negsrc_e ALT_A_SRC = dcc_pkg::DCC_SRC_CHARGE_TIME,
    parameter dcc_pkg::dcc_negsrc_e ALT_B_SRC = dcc_pkg::DCC_SRC_EXTRA_PIN
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcc_pkg::DCC_APB_AW-1:0] paddr,
    input wire logic [dcc_pkg::DCC_APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [dcc_pkg::DCC_APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dcc_pkg::DCC_NCH-1:0] comp_raw,
    output dcc_pkg::dcc_analog_s [dcc_pkg::DCC_NCH-1:0] analog_ctrl,
    output logic [dcc_pkg::DCC_NCH-1:0] comparator_output_pin,
    output logic [dcc_pkg::DCC_NCH-1:0] comparator_output_pin_oe,
    output logic [dcc_pkg::DCC_NCH-1:0] comparator_event_flag
);
    import dcc_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    // registered state and its next values come first,
    // then the decode helpers that feed them
    dcc_ctrl_s ctrl [DCC_NCH];
    dcc_ctrl_s next_ctrl [DCC_NCH];
    logic [DCC_NCH-1:0] flag;
    logic [DCC_NCH-1:0] next_flag;
    logic [DCC_NCH-1:0] pin_q;
    logic [DCC_NCH-1:0] next_pin_q;
    logic [DCC_NCH-1:0] pin_oe_q;
    logic [DCC_NCH-1:0] next_pin_oe_q;
    logic [DCC_APB_DW-1:0] rdata_q;
    logic [DCC_APB_DW-1:0] next_rdata_q;
    logic [DCC_NCH-1:0] raw_sync;
    logic [DCC_NCH-1:0] result;
    logic [DCC_NCH-1:0] event_hit;
    logic [DCC_NCH-1:0] any_mode_set;
    logic [DCC_NCH-1:0] ctrl_hit;
    logic [DCC_REG_W-1:0] wbyte;
    logic [DCC_REG_W-1:0] status_byte;
    logic [DCC_REG_W-1:0] flag_byte;
    logic hit_status;
    logic hit_flag;
    logic mapped;
    logic setup_rd;
    logic access_wr;
    logic lane0;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------

    // bus timing at a glance:
    //   setup edge - read data for the addressed register is captured
    //   access edge - a write lands; pready is already high
    // a write with pstrb[0] low completes normally but changes nothing,
    // since every register lives in the low byte lane
    // the flag register sits just above the two control slots,
    // with its bits 6:5 lined up with the two event flags
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign hit_status = (paddr == DCC_ADDR_STATUS);
    assign hit_flag = (paddr == DCC_ADDR_FLAG);
    assign ctrl_hit[0] = (paddr == DCC_ADDR_CTRL_LO);
    assign ctrl_hit[1] = (paddr == DCC_ADDR_CTRL_HI);
    assign mapped = hit_status | hit_flag | (|ctrl_hit);
    // unmapped addresses answer with an error, writes there change nothing
    assign pslverr = psel & penable & ~mapped;
    assign setup_rd = ce & psel & ~penable & ~pwrite;
    assign lane0 = pstrb[0];
    // writes take effect only at the completing access edge
    assign access_wr = ce & psel & penable & pwrite & lane0;
    assign wbyte = pwdata[DCC_REG_W-1:0];
    assign prdata = rdata_q;

    // ------------------------------------------------------------------
    // comparator result path
    // ------------------------------------------------------------------

    // the raw outputs come from the analog cores with no relation to the
    // clock; nothing reads them before the second synchroniser stage,
    // so a metastable first stage has a whole cycle to settle
    // limitation: a level shorter than a clock period may be missed
    // raw outputs synchronised
    dcc_sync #(
        .W(DCC_NCH),
        .RESET_LEVEL(DCC_RESULT_RESET)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(comp_raw),
        .sync_out(raw_sync)
    );

    // one independent channel per comparator
    // each keeps its own history, so the two never share an edge
    genvar gi;
    generate
        for (gi = 0; gi < DCC_NCH; gi++) begin : g_ch
            dcc_channel u_ch (
                .clock(clock),
                .rst_n(rst_n),
                .ce(ce),
                .ctrl(ctrl[gi]),
                .raw_sync(raw_sync[gi]),
                .result(result[gi]),
                .event_hit(event_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // analog steering
    // ------------------------------------------------------------------

    // codes 01 and 10 are left to parameters so an integration can point
    // them at whichever spare inverting-side sources it has; the core is
    // told the source, not the raw code, to keep the decode in one place
    // decode control fields into core enable and input multiplexers
    always_comb begin
        for (int i = 0; i < DCC_NCH; i++) begin
            analog_ctrl[i].enable = ctrl[i].comparator_on;
            analog_ctrl[i].pos_from_ladder = ctrl[i].positive_ref_select;
            unique case (ctrl[i].negative_channel_select)
                DCC_NEG_PIN: analog_ctrl[i].neg_source = DCC_SRC_NEG_PIN;
                DCC_NEG_ALT_A: analog_ctrl[i].neg_source = ALT_A_SRC;
                DCC_NEG_ALT_B: analog_ctrl[i].neg_source = ALT_B_SRC;
                DCC_NEG_FIXED: analog_ctrl[i].neg_source = DCC_SRC_FIXED_REF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------

    // the auto flag fires only when a write moves the mode into any-change;
    // rewriting the same mode leaves a cleared flag alone, so software
    // can finish its setup without the flag coming back
    // control next values; a byte write replaces the whole field set
    always_comb begin
        for (int i = 0; i < DCC_NCH; i++) begin
            next_ctrl[i] = ctrl[i];
            any_mode_set[i] = 1'b0;
            if (access_wr && ctrl_hit[i]) begin
                next_ctrl[i] = dcc_ctrl_s'(wbyte);
                any_mode_set[i] = (next_ctrl[i].event_polarity_select == DCC_EV_ANY)
                    && (ctrl[i].event_polarity_select != DCC_EV_ANY);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DCC_NCH; i++) begin
                ctrl[i] <= dcc_ctrl_s'(DCC_CTRL_RESET);
            end
        end else begin
            for (int i = 0; i < DCC_NCH; i++) begin
                ctrl[i] <= next_ctrl[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------------

    // software write first, hardware set on top so an event is never lost
    // event_hit is already gated by ce, the bus write by access_wr
    always_comb begin
        next_flag = flag;
        if (access_wr && hit_flag) begin
            next_flag = wbyte[DCC_FLAG_LSB +: DCC_NCH];
        end
        next_flag = next_flag | event_hit | any_mode_set;
    end

    // flag registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag <= DCC_FLAG_RESET[DCC_FLAG_LSB +: DCC_NCH];
        end else begin
            flag <= next_flag;
        end
    end

    assign comparator_event_flag = flag;

    // ------------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------------

    // pins are registered so the remap multiplexer sees clean levels
    // the enable follows comparator_on too: a core that is off never
    // drives its remapped pin, whatever output_pin_enable says
    always_comb begin
        next_pin_q = pin_q;
        next_pin_oe_q = pin_oe_q;
        if (ce) begin
            next_pin_q = result;
            for (int i = 0; i < DCC_NCH; i++) begin
                next_pin_oe_q[i] = ctrl[i].comparator_on & ctrl[i].output_pin_enable;
            end
        end
    end

    // pin registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= {DCC_NCH{DCC_RESULT_RESET}};
            pin_oe_q <= '0;
        end else begin
            pin_q <= next_pin_q;
            pin_oe_q <= next_pin_oe_q;
        end
    end

    assign comparator_output_pin = pin_q;
    assign comparator_output_pin_oe = pin_oe_q;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // unimplemented status bits and the upper data lanes always read zero
    // status bits 1-0 only
    always_comb begin
        status_byte = '0;
        status_byte[DCC_STATUS_LSB +: DCC_NCH] = result;
        flag_byte = '0;
        flag_byte[DCC_FLAG_LSB +: DCC_NCH] = flag;
    end

    // read data captured in the setup cycle, stable for the access cycle;
    // a status sample is therefore one cycle older than the access edge
    // trade-off: polling sees results a cycle late, but prdata stays off
    // the comparator path for the whole access phase
    always_comb begin
        next_rdata_q = rdata_q;
        if (setup_rd) begin
            next_rdata_q = '0;
            if (hit_status) begin
                next_rdata_q[DCC_REG_W-1:0] = status_byte;
            end else if (hit_flag) begin
                next_rdata_q[DCC_REG_W-1:0] = flag_byte;
            end else if (ctrl_hit[0]) begin
                next_rdata_q[DCC_REG_W-1:0] = ctrl[0];
            end else if (ctrl_hit[1]) begin
                next_rdata_q[DCC_REG_W-1:0] = ctrl[1];
            end
        end
    end

    // read data register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= next_rdata_q;
        end
    end
endmodule // dcc_top

/* tb/dcc_assertions.sv */
// port-level checks for the dual comparator control block
`timescale 1ns/1ns
module dcc_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcc_pkg::DCC_APB_AW-1:0] paddr,
    input wire logic [dcc_pkg::DCC_APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [dcc_pkg::DCC_APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [dcc_pkg::DCC_NCH-1:0] comp_raw,
    input wire dcc_pkg::dcc_analog_s [dcc_pkg::DCC_NCH-1:0] analog_ctrl,
    input wire logic [dcc_pkg::DCC_NCH-1:0] comparator_output_pin,
    input wire logic [dcc_pkg::DCC_NCH-1:0] comparator_output_pin_oe,
    input wire logic [dcc_pkg::DCC_NCH-1:0] comparator_event_flag
);
    import dcc_pkg::*;
    logic wr;
    logic fw;
    logic [7:0] sh1;
    logic [7:0] next_sh1;
    // ----------------------------------------------------------------
    // shadow of control 1
    // ----------------------------------------------------------------
    assign wr = psel & penable & pwrite & ce & pstrb[0];
    assign fw = wr && paddr == DCC_ADDR_FLAG;
    // follows completed writes only
    always_comb begin
        next_sh1 = sh1;
        if (wr && paddr == DCC_ADDR_CTRL_HI) begin
            next_sh1 = pwdata[7:0];
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sh1 <= DCC_CTRL_RESET;
        end else begin
            sh1 <= next_sh1;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // on and untouched long enough to refill the synchroniser
    sequence s_steady;
        (sh1[7] && $stable(sh1)) [*5];
    endsequence
    property p_steer;
        wr && paddr == DCC_ADDR_CTRL_HI |=> analog_ctrl[1].enable == $past(pwdata[7])
            && analog_ctrl[1].pos_from_ladder == $past(pwdata[2]);
    endproperty
    a_steer: assert property (p_steer) else $error("steering differs");
    property p_oe;
        wr && paddr == DCC_ADDR_CTRL_LO |-> ##2
            comparator_output_pin_oe[0] == $past(pwdata[7] & pwdata[6], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_pin;
        s_steady |-> comparator_output_pin[1] == ($past(comp_raw[1], 3) ^ sh1[5]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin level wrong");
    property p_event;
        s_steady ##0 (sh1[3] && ($past(comp_raw[1], 3) ^ sh1[5]) > ($past(comp_raw[1], 4) ^ sh1[5])
            || sh1[4] && ($past(comp_raw[1], 3) ^ sh1[5]) < ($past(comp_raw[1], 4) ^ sh1[5]))
            |-> comparator_event_flag[1];
    endproperty
    a_event: assert property (p_event) else $error("edge missed");
    property p_sticky;
        comparator_event_flag[1] && !(fw && !pwdata[6]) |=> comparator_event_flag[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_swset;
        fw && pwdata[6] |=> comparator_event_flag[1];
    endproperty
    a_swset: assert property (p_swset) else $error("flag not set by write");
    property p_auto;
        wr && paddr == DCC_ADDR_CTRL_HI && pwdata[4:3] == 2'h3 && sh1[4:3] != 2'h3
            |-> ##[1:2] comparator_event_flag[1];
    endproperty
    a_auto: assert property (p_auto) else $error("no flag on any-change mode");
    property p_quiet;
        (!sh1[7] && !wr) [*4] |=> !$rose(comparator_event_flag[1]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("event while off");
endmodule // dcc_assertions

bind dcc_top dcc_assertions i_dcc_assertions (
    .clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw), .analog_ctrl(analog_ctrl),
    .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe),
    .comparator_event_flag(comparator_event_flag)
);

/* tb/dcc_analog_model.sv */
// behavioural model of the two analog comparator cores
`timescale 1ns/1ns
module dcc_analog_model #(
    parameter int DLY = 3
) (
    input wire dcc_pkg::dcc_analog_s [1:0] analog_ctrl,
    input wire logic [1:0][5:0][7:0] volts,
    output wire logic [1:0] comp_raw
);
    import dcc_pkg::*;
    logic [1:0] idle = 2'h1;
    // an unpowered core gives no usable level, so it wobbles
    always #7 idle = ~idle;
    // selected pins taken as analog inputs
    // volts index: 0 pos pin, 1 ladder, 2 neg pin, 3 charge-time, 4 extra pin, 5 fixed
    for (genvar i = 0; i < 2; i++) begin : g_core
        wire logic [7:0] vp = volts[i][analog_ctrl[i].pos_from_ladder];
        wire logic [7:0] vm = volts[i][3'h2 + analog_ctrl[i].neg_source];
        // high when above, slow to respond
        assign #DLY comp_raw[i] = analog_ctrl[i].enable ? (vp > vm) : idle[i];
    end
endmodule // dcc_analog_model

/* tb/dcc_top_bench.sv */
// self-checking bench for the dual comparator control block
`timescale 1ns/1ns
module dcc_top_bench;
    import dcc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] comp_raw;
    dcc_analog_s [1:0] analog_ctrl;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    logic [1:0] flag;
    logic [1:0][5:0][7:0] volts = '0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    dcc_top i_dcc_top (
        .clock(clock), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw), .analog_ctrl(analog_ctrl),
        .comparator_output_pin(pin), .comparator_output_pin_oe(pin_oe),
        .comparator_event_flag(flag)
    );
    dcc_analog_model #(.DLY(3)) i_dcc_analog_model (
        .analog_ctrl(analog_ctrl), .volts(volts), .comp_raw(comp_raw)
    );

    initial begin
        forever #5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    // one transfer, then an idle edge so the next call starts clean
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rdck(input string nm, input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic results();
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdck("ctrl0", DCC_ADDR_CTRL_LO, 32'h1f);
        rdck("ctrl1", DCC_ADDR_CTRL_HI, 32'h1f);
        rdck("status", DCC_ADDR_STATUS, 32'h3);
        rdck("flags", DCC_ADDR_FLAG, 32'h0);
        chk("enable", 32'h0, {30'h0, analog_ctrl[1].enable, analog_ctrl[0].enable});
    endtask
    task automatic t_refuse();
        apb(1'b1, DCC_ADDR_STATUS, 32'hff);
        rdck("status ro", DCC_ADDR_STATUS, 32'h3);
        apb(1'b0, 16'h0100, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
    endtask
    // every input pairing with and without inversion on channel 0
    task automatic t_inputs();
        logic e;
        volts <= {48'h000000800000, 48'h60a030509040};
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, DCC_ADDR_CTRL_LO, {24'h0, 2'h3, c[3], 2'h0, c[2], c[1:0]});
            e = (volts[0][c[2]] > volts[0][3'h2 + c[1:0]]) ^ c[3];
            repeat (4) @(posedge clock);
            rdck("result0", DCC_ADDR_STATUS, {30'h0, 1'b1, e});
            chk("pin0", {31'h0, e}, {31'h0, pin[0]});
        end
        chk("oe0", 32'h1, {31'h0, pin_oe[0]});
    endtask
    // each event mode on channel 1, rising then falling input
    task automatic t_events();
        for (int m = 0; m < 4; m++) begin
            volts[1][0] <= 8'h10;
            apb(1'b1, DCC_ADDR_CTRL_HI, {24'h0, 3'h4, m[1:0], 3'h0});
            repeat (5) @(posedge clock);
            apb(1'b1, DCC_ADDR_FLAG, 32'h0);
            volts[1][0] <= 8'hf0;
            repeat (5) @(posedge clock);
            rdck("rise flag", DCC_ADDR_FLAG, {25'h0, m[0], 6'h0});
            apb(1'b1, DCC_ADDR_FLAG, 32'h0);
            volts[1][0] <= 8'h10;
            repeat (5) @(posedge clock);
            rdck("fall flag", DCC_ADDR_FLAG, {25'h0, m[1], 6'h0});
        end
        apb(1'b1, DCC_ADDR_CTRL_HI, 32'h88);
        apb(1'b1, DCC_ADDR_FLAG, 32'h0);
        apb(1'b1, DCC_ADDR_CTRL_HI, 32'ha8);
        repeat (5) @(posedge clock);
        rdck("invert edge", DCC_ADDR_FLAG, 32'h40);
    endtask
    task automatic t_flags();
        apb(1'b1, DCC_ADDR_FLAG, 32'h0);
        apb(1'b1, DCC_ADDR_CTRL_LO, 32'hbf);
        rdck("auto flag", DCC_ADDR_FLAG, 32'h20);
        apb(1'b1, DCC_ADDR_FLAG, 32'h40);
        rdck("sw set", DCC_ADDR_FLAG, 32'h40);
        apb(1'b1, DCC_ADDR_CTRL_LO, 32'hbf);
        rdck("rewrite", DCC_ADDR_FLAG, 32'h40);
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_refuse();
        t_inputs();
        t_events();
        t_flags();
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        results();
    end
    // whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
endmodule // dcc_top_bench
